// ==== gti_pkg.sv ====
// Purpose: Shared constants and types for the gauge I2C target interface
// Assumes: 10 MHz core clock, SCL and SDA sampled as asynchronous inputs
// Notes: Command space layout and timing figures live here only
package gti_pkg;
    // =====================================================================
    // Bus addressing
    localparam logic [6:0] TGT_ADDR = 7'h55;          // Fixed 1010101
    localparam logic [7:0] WR_BYTE = 8'haa;
    localparam logic [7:0] RD_BYTE = 8'hab;
    // =====================================================================
    // Command space
    localparam logic [7:0] CMD_TOP = 8'h6b;           // Highest readable code
    localparam logic [7:0] DCLASS_LOC = 8'h3e;
    localparam logic [7:0] DBLOCK_LOC = 8'h3f;
    localparam int MEM_DEPTH = 128;
    // =====================================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TOUT_MS = 2000;                    // Bus-low timeout
    localparam int TOUT_CYC = TOUT_MS * (CLK_HZ / 1000);
    localparam int WAKE_US = 100;                     // Stretch in low power
    localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1_000_000);
    localparam int BUSY_MS = 4;                       // Stretch in normal mode
    localparam int BUSY_CYC = BUSY_MS * (CLK_HZ / 1000);
    localparam int SETTLE_CYC = 8;                    // Filter delay margin after release
    // =====================================================================
    // Types
    typedef enum logic [1:0] {
        MODE_INIT = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_SLEEP = 2'b10,
        MODE_HIBERNATE = 2'b11
    } gti_mode_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } gti_bus_type;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } gti_wr_type;
endpackage

// ==== gti_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for bus pins
// Assumes: Inputs asynchronous to clk_in
// Notes: Output changes only when stages two and three agree
`timescale 1ns/100ps
module gti_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire gti_pkg::gti_bus_type raw_in,
    output gti_pkg::gti_bus_type clean_out
);
    gti_pkg::gti_bus_type s1_r;
    gti_pkg::gti_bus_type s2_r;
    gti_pkg::gti_bus_type s3_r;

    // =====================================================================
    // Chain; idle bus is high so reset to high avoids a false start
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            clean_out <= '1;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r.scl == s3_r.scl) begin
                clean_out.scl <= s3_r.scl;
            end
            if (s2_r.sda == s3_r.sda) begin
                clean_out.sda <= s3_r.sda;
            end
        end
    end
endmodule

// ==== gti_target.sv ====
// Purpose: I2C target engine of a single-cell fuel gauge
// Assumes: SCL from the master, sampled by clk_in; open-drain pins
// Notes: Command locations held in a local array, core side via ports
// =====================================================================
`timescale 1ns/100ps
module gti_target (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire gti_pkg::gti_mode_type mode_in,
    input wire logic sealed_in,
    input wire logic core_busy_in,
    input wire logic [gti_pkg::MEM_DEPTH-1:0] ro_map_in,
    input wire logic wdog_kick_in,
    output gti_pkg::gti_wr_type wr_out,
    output logic sleep_req_out,
    output logic wdog_reset_out
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_ACK = 3'b101,
        ST_MACK = 3'b110,
        ST_IGNORE = 3'b111
    } gti_state_type;

    gti_pkg::gti_bus_type bus;
    gti_pkg::gti_bus_type bus_r;
    gti_state_type state_r;
    gti_state_type after_ack_r;
    logic [7:0] mem_r [gti_pkg::MEM_DEPTH];
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [3:0] bit_cnt_r;
    logic ack_drive_r;
    logic rd_drive_r;
    logic stretch_r;
    logic [23:0] stretch_cnt_r;
    logic [24:0] low_cnt_r;
    logic [24:0] wdog_cnt_r;
    logic released_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] byte_in;
    logic loc_blocked;
    logic [23:0] stretch_lim;

    // =====================================================================
    // Pin sampling
    gti_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .raw_in({scl_in, sda_in}),
        .clean_out(bus)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_r <= '1;
        end else begin
            bus_r <= bus;
        end
    end

    // Edge and condition detection on filtered lines
    assign scl_rise = bus.scl && !bus_r.scl;
    assign scl_fall = !bus.scl && bus_r.scl;
    assign start_det = bus.scl && bus_r.scl && bus_r.sda && !bus.sda;
    assign stop_det = bus.scl && bus_r.scl && !bus_r.sda && bus.sda;
    assign byte_in = {shift_r[6:0], bus.sda};

    // Sealed mode hides the data class and block locations
    assign loc_blocked = sealed_in && (ptr_r == gti_pkg::DCLASS_LOC
        || ptr_r == gti_pkg::DBLOCK_LOC);

    // =====================================================================
    // Byte engine
    always_ff @(posedge clk_in) begin
        if (rst_in || released_r) begin
            state_r <= ST_IDLE;
            after_ack_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            ack_drive_r <= 1'b0;
            rd_drive_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;          // Also covers repeated start
            bit_cnt_r <= 4'h0;
            ack_drive_r <= 1'b0;
            rd_drive_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            ack_drive_r <= 1'b0;
            rd_drive_r <= 1'b0;
        end else if (!stretch_r) begin
            if (scl_rise && (state_r == ST_ADDR || state_r == ST_CMD
                || state_r == ST_WDATA)) begin
                shift_r <= byte_in;
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_rise && state_r == ST_MACK) begin
                // Master ACK continues, NACK ends the read
                after_ack_r <= bus.sda ? ST_IGNORE : ST_RDATA;
            end
            if (scl_fall) begin
                case (state_r)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        if (bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            state_r <= ST_ACK;
                            ack_drive_r <= 1'b0;
                            after_ack_r <= ST_IGNORE;
                            if (state_r == ST_ADDR) begin
                                if (shift_r == gti_pkg::WR_BYTE) begin
                                    ack_drive_r <= 1'b1;
                                    after_ack_r <= ST_CMD;
                                end else if (shift_r == gti_pkg::RD_BYTE) begin
                                    ack_drive_r <= 1'b1;
                                    after_ack_r <= ST_RDATA;
                                end
                            end else if (state_r == ST_CMD) begin
                                ack_drive_r <= (shift_r <= gti_pkg::CMD_TOP);
                                after_ack_r <= ST_WDATA;
                            end else begin
                                ack_drive_r <= !ro_map_in[ptr_r[6:0]] && !loc_blocked;
                                after_ack_r <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        ack_drive_r <= 1'b0;
                        state_r <= ack_drive_r ? after_ack_r : ST_IGNORE;
                        rd_drive_r <= ack_drive_r && after_ack_r == ST_RDATA;
                        shift_r <= (ack_drive_r && after_ack_r == ST_RDATA)
                            ? (loc_blocked ? 8'h00 : mem_r[ptr_r[6:0]]) : shift_r;
                    end
                    ST_RDATA: begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7) begin
                            bit_cnt_r <= 4'h0;
                            rd_drive_r <= 1'b0;
                            state_r <= ST_MACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                    ST_MACK: begin
                        state_r <= after_ack_r;
                        rd_drive_r <= after_ack_r == ST_RDATA;
                        shift_r <= loc_blocked ? 8'h00 : mem_r[ptr_r[6:0]];
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // Address pointer; command byte loads it, acknowledged bytes advance it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ptr_r <= 8'h00;
        end else if (!stretch_r && scl_fall && bit_cnt_r == 4'h8 && state_r == ST_CMD
            && shift_r <= gti_pkg::CMD_TOP) begin
            ptr_r <= shift_r;
        end else if (!stretch_r && scl_rise && state_r == ST_MACK && !bus.sda) begin
            ptr_r <= ptr_r + 8'h01;
        end else if (!stretch_r && scl_fall && state_r == ST_WDATA && bit_cnt_r == 4'h8
            && !ro_map_in[ptr_r[6:0]] && !loc_blocked) begin
            // Same edge as the store, which still sees the old pointer
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // Store accepted write data, one strobe per byte
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_out <= '0;
        end else begin
            wr_out.we <= 1'b0;
            if (!stretch_r && scl_fall && state_r == ST_WDATA && bit_cnt_r == 4'h8
                && !ro_map_in[ptr_r[6:0]] && !loc_blocked) begin
                wr_out.we <= 1'b1;
                wr_out.addr <= ptr_r;
                wr_out.data <= shift_r;
                mem_r[ptr_r[6:0]] <= shift_r;
            end
        end
    end

    // =====================================================================
    // Clock stretch, bounded by the mode's limit
    assign stretch_lim = (mode_in == gti_pkg::MODE_SLEEP
        || mode_in == gti_pkg::MODE_HIBERNATE)
        ? 24'(gti_pkg::WAKE_CYC) : 24'(gti_pkg::BUSY_CYC);

    always_ff @(posedge clk_in) begin
        if (rst_in || released_r || state_r == ST_IDLE) begin
            stretch_r <= 1'b0;
            stretch_cnt_r <= 24'h000000;
        end else if (stretch_r) begin
            stretch_cnt_r <= stretch_cnt_r + 24'h000001;
            if (!core_busy_in || stretch_cnt_r >= stretch_lim - 24'h000001) begin
                stretch_r <= 1'b0;
            end
        end else if (scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'h8
            && core_busy_in) begin
            stretch_r <= 1'b1;           // Busy hold on the address byte, limit set by mode
            stretch_cnt_r <= 24'h000000;
        end
    end

    // =====================================================================
    // Bus-low timeout, release and sleep request
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low_cnt_r <= '0;
            released_r <= 1'b0;
            sleep_req_out <= 1'b0;
        end else if (bus.scl && bus.sda) begin
            low_cnt_r <= '0;
            released_r <= 1'b0;
            sleep_req_out <= 1'b0;
        end else begin
            // Count past release so our own let-go reaches the filter first
            if (low_cnt_r < 25'(gti_pkg::TOUT_CYC + gti_pkg::SETTLE_CYC)) begin
                low_cnt_r <= low_cnt_r + 25'h0000001;
            end
            if (low_cnt_r >= 25'(gti_pkg::TOUT_CYC - 1)) begin
                released_r <= 1'b1;
            end
            if (low_cnt_r >= 25'(gti_pkg::TOUT_CYC + gti_pkg::SETTLE_CYC)) begin
                sleep_req_out <= 1'b1;
            end
        end
    end

    // Watchdog: expires if not kicked within the timeout window
    always_ff @(posedge clk_in) begin
        if (rst_in || wdog_kick_in) begin
            wdog_cnt_r <= '0;
            wdog_reset_out <= 1'b0;
        end else if (wdog_cnt_r >= 25'(gti_pkg::TOUT_CYC - 1)) begin
            wdog_reset_out <= 1'b1;
        end else begin
            wdog_cnt_r <= wdog_cnt_r + 25'h0000001;
        end
    end

    // =====================================================================
    // Open-drain drivers: only ever pull low
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe_out = !released_r && (ack_drive_r && state_r == ST_ACK
        || rd_drive_r && !shift_r[7]);
    assign scl_oe_out = !released_r && stretch_r;
endmodule

// ==== gti_asserts.sv ====
// Purpose: Port-level timing and refusal checks for the gauge I2C target
// Assumes: Mode and read-only map held steady while a stretch is live
// Notes: Bus-low timeout is too long for the bench, checked here alone
`timescale 1ns/100ps
module gti_asserts (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire gti_pkg::gti_mode_type mode_in,
    input wire logic sealed_in,
    input wire logic [gti_pkg::MEM_DEPTH-1:0] ro_map_in,
    input wire gti_pkg::gti_wr_type wr_out,
    input wire logic sleep_req_out
);
    // =====================================================================
    // Length of the current hold on each line
    logic [31:0] scl_cnt_r;
    logic [31:0] sda_cnt_r;
    always_ff @(posedge clk_in) begin
        scl_cnt_r <= (rst_in || !scl_oe_out) ? 32'h0 : scl_cnt_r + 32'h1;
    end
    always_ff @(posedge clk_in) begin
        sda_cnt_r <= (rst_in || !sda_oe_out) ? 32'h0 : sda_cnt_r + 32'h1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // =====================================================================
    // Properties
    property p_open_drain;
        !scl_out && !sda_out;
    endproperty
    property p_lp_stretch;
        (mode_in == gti_pkg::MODE_SLEEP || mode_in == gti_pkg::MODE_HIBERNATE)
            |-> scl_cnt_r <= gti_pkg::WAKE_CYC;
    endproperty
    property p_stretch;
        scl_cnt_r <= gti_pkg::BUSY_CYC;
    endproperty
    property p_tout_sda;
        sda_cnt_r <= gti_pkg::TOUT_CYC;
    endproperty
    property p_ro;
        wr_out.we |-> !ro_map_in[wr_out.addr[6:0]];
    endproperty
    property p_sealed;
        wr_out.we && sealed_in |->
            wr_out.addr != gti_pkg::DCLASS_LOC && wr_out.addr != gti_pkg::DBLOCK_LOC;
    endproperty
    property p_we_pulse;
        wr_out.we |=> (!wr_out.we) [*8];
    endproperty
    property p_drive_hold;
        $rose(sda_oe_out) |-> sda_oe_out [*4];
    endproperty
    property p_sleep_free;
        sleep_req_out |-> !scl_oe_out && !sda_oe_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("bus pin driven high");
    a_lp_stretch: assert property (p_lp_stretch) else $error("low power stretch long");
    a_stretch: assert property (p_stretch) else $error("clock stretch too long");
    a_tout_sda: assert property (p_tout_sda) else $error("sda held past timeout");
    a_ro: assert property (p_ro) else $error("read-only location stored");
    a_sealed: assert property (p_sealed) else $error("sealed location stored");
    a_we_pulse: assert property (p_we_pulse) else $error("stores too close");
    a_drive_hold: assert property (p_drive_hold) else $error("sda drive too short");
    a_sleep_free: assert property (p_sleep_free) else $error("lines held in sleep");
    c_write: cover property (wr_out.we);
    c_stretch: cover property ($rose(scl_oe_out));
    c_drive: cover property ($rose(sda_oe_out));
endmodule

bind gti_target gti_asserts u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .scl_out(scl_out),
    .scl_oe_out(scl_oe_out),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .mode_in(mode_in),
    .sealed_in(sealed_in),
    .ro_map_in(ro_map_in),
    .wr_out(wr_out),
    .sleep_req_out(sleep_req_out)
);

// ==== gti_host.sv ====
// Purpose: Behavioural I2C bus master facing the gauge target
// Assumes: Pull-ups on both lines, steps taken at falling core clock edges
// Notes: SCL low 5 and high 3 core cycles, stands high between frames
`timescale 1ns/100ps
module gti_host (
    input wire logic clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_out,
    output logic sda_oe_out
);
    int st_max;
    logic tmo;
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
        st_max = 0;
        tmo = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Release SCL, bounded wait while the target stretches
    task automatic rise();
        int n;
        scl_oe_out = 1'b0;
        tick(1);
        n = 0;
        while (scl_in !== 1'b1 && n < 60000) begin
            tick(1);
            n++;
        end
        if (n >= 60000) tmo = 1'b1;
        if (n > st_max) st_max = n;
    endtask
    task automatic bit_io(input logic v, output logic s);
        tick(2);
        sda_oe_out = !v;
        tick(3);
        rise();
        tick(1);
        s = sda_in;
        tick(1);
        scl_oe_out = 1'b1;
    endtask
    // Start and repeated start alike: SDA falls with SCL high
    task automatic start();
        tick(2);
        sda_oe_out = 1'b0;
        tick(3);
        rise();
        tick(3);
        sda_oe_out = 1'b1;
        tick(3);
        scl_oe_out = 1'b1;
    endtask
    task automatic stop();
        tick(2);
        sda_oe_out = 1'b1;
        tick(3);
        rise();
        tick(3);
        sda_oe_out = 1'b0;
        tick(660);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the gauge I2C target
// Assumes: Master model sends one-byte writes at this SCL rate
// Notes: Timeout and watchdog periods are beyond the run length
`timescale 1ns/100ps
module tb_top;
    logic clk_in;
    logic rst_in;
    logic scl_oe_d, sda_oe_d, scl_oe_h, sda_oe_h, scl_o, sda_o;
    logic sealed, busy, kick, sleep_req, wdog_rst;
    logic [gti_pkg::MEM_DEPTH-1:0] ro_map;
    gti_pkg::gti_mode_type mode;
    gti_pkg::gti_wr_type wr;
    wire scl = !(scl_oe_d || scl_oe_h);
    wire sda = !(sda_oe_d || sda_oe_h);
    int failures;
    int n_checks;
    logic [15:0] wq[$];
    gti_target DUT (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .scl_out(scl_o),
        .scl_oe_out(scl_oe_d), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe_d),
        .mode_in(mode), .sealed_in(sealed), .core_busy_in(busy), .ro_map_in(ro_map),
        .wdog_kick_in(kick), .wr_out(wr), .sleep_req_out(sleep_req),
        .wdog_reset_out(wdog_rst));
    gti_host HOST (.clk_in(clk_in), .scl_in(scl), .sda_in(sda),
        .scl_oe_out(scl_oe_h), .sda_oe_out(sda_oe_h));
    // =====================================================================
    // Clock, watchdog kicks and store log
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // Core stands in for pacing and update time; it only services the watchdog
    always begin
        kick = 1'b0;
        repeat (1000) @(negedge clk_in);
        kick = 1'b1;
        @(negedge clk_in);
    end
    always @(negedge clk_in) if (wr.we === 1'b1) wq.push_back({wr.addr, wr.data});
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr_pkt(input logic [7:0] a, c, d, output logic [2:0] k);
        HOST.start();
        HOST.wbyte(a, k[2]);
        HOST.wbyte(c, k[1]);
        HOST.wbyte(d, k[0]);
        HOST.stop();
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_write_read();
        logic [2:0] k;
        logic a;
        logic [7:0] d0, d1;
        wq.delete();
        wr_pkt(gti_pkg::WR_BYTE, 8'h11, 8'h5a, k);
        check("wr_acks", 16'(k), 16'h7);
        wr_pkt(gti_pkg::WR_BYTE, 8'h10, 8'ha5, k);
        check("wr_log0", wq[0], 16'h115a);
        check("wr_log1", wq[1], 16'h10a5);
        // Stored byte steps the pointer, so a quick read gives location 0x11
        HOST.start();
        HOST.wbyte(gti_pkg::RD_BYTE, a);
        HOST.rbyte(1'b0, d0);
        HOST.stop();
        check("wr_adv", 16'(d0), 16'h5a);
        HOST.start();
        HOST.wbyte(gti_pkg::WR_BYTE, a);
        HOST.wbyte(8'h10, a);
        HOST.start();
        HOST.wbyte(gti_pkg::RD_BYTE, a);
        check("rd_ack", 16'(a), 16'h1);
        HOST.rbyte(1'b1, d0);
        HOST.rbyte(1'b0, d1);
        HOST.stop();
        check("rd_pair", {d0, d1}, 16'ha55a);
        HOST.start();
        HOST.wbyte(gti_pkg::RD_BYTE, a);
        HOST.rbyte(1'b0, d0);
        HOST.stop();
        check("quick", 16'(d0), 16'h5a);
    endtask
    // Refused writes must leave nothing in the store log
    task automatic t_refuse();
        logic [2:0] k;
        logic a;
        wq.delete();
        ro_map[8'h20] = 1'b1;
        wr_pkt(gti_pkg::WR_BYTE, 8'h20, 8'h77, k);
        check("ro_wr", 16'(k), 16'h6);
        sealed = 1'b1;
        wr_pkt(gti_pkg::WR_BYTE, gti_pkg::DCLASS_LOC, 8'h77, k);
        check("seal_cls", 16'(k), 16'h6);
        wr_pkt(gti_pkg::WR_BYTE, gti_pkg::DBLOCK_LOC, 8'h77, k);
        check("seal_blk", 16'(k), 16'h6);
        sealed = 1'b0;
        wr_pkt(8'hac, 8'h10, 8'h77, k);
        check("foreign", 16'(k), 16'h0);
        wr_pkt(8'h54, 8'h10, 8'h77, k);
        check("other_addr", 16'(k), 16'h0);
        check("no_store", 16'(wq.size()), 16'h0);
        for (int c = 8'h6b; c <= 8'h6c; c++) begin
            HOST.start();
            HOST.wbyte(gti_pkg::WR_BYTE, a);
            HOST.wbyte(8'(c), a);
            HOST.stop();
            check("cmd_top", 16'(a), 16'(c == 8'h6b));
        end
    endtask
    // Core held busy: stretch must end at the mode's limit
    task automatic t_stretch();
        logic [2:0] k;
        int lim;
        for (int i = 0; i < 4; i++) begin
            mode = gti_pkg::gti_mode_type'(i);
            lim = (i >= 2) ? gti_pkg::WAKE_CYC : gti_pkg::BUSY_CYC;
            busy = 1'b1;
            HOST.st_max = 0;
            wr_pkt(gti_pkg::WR_BYTE, 8'h12, 8'h00, k);
            check("st_len", 16'(HOST.st_max + 8 >= lim && HOST.st_max <= lim + 8), 16'h1);
        end
        busy = 1'b0;
        HOST.st_max = 0;
        wr_pkt(gti_pkg::WR_BYTE, 8'h12, 8'h00, k);
        check("st_idle", 16'(HOST.st_max < 8), 16'h1);
    endtask
    // =====================================================================
    // Main sequence and overall time limit
    initial begin
        rst_in = 1'b1;
        mode = gti_pkg::MODE_NORMAL;
        sealed = 1'b0;
        busy = 1'b0;
        ro_map = '0;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        t_write_read();
        t_refuse();
        t_stretch();
        check("host_tmo", 16'(HOST.tmo), 16'h0);
        check("wdog", 16'(wdog_rst), 16'h0);
        check("sleep", 16'(sleep_req), 16'h0);
        give_verdict();
    end
    initial begin
        repeat (110000) @(posedge clk_in);
        failures++;
        give_verdict();
    end
endmodule
